// [hw/rdm_buf2.sv]
/*
  small valid/ready buffer, DEPTH entries of W bits.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module rdm_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,       // core clock
  input  wire logic         rstn,      // async reset, low
  input  wire logic         clr,       // drop all entries
  input  wire logic         in_valid,  // source has a word
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // source word
  output logic              out_valid, // word available
  input  wire logic         out_ready, // sink takes word
  output logic [W-1:0]      out_data   // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // handshakes and pointer arithmetic
  assign in_ready  = (cnt_reg != FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready & ~clr;
  assign pop       = out_valid & out_ready & ~clr;

  always_comb begin
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (clr) begin
      wp_next  = '0;
      rp_next  = '0;
      cnt_next = '0;
    end else begin
      if (push) wp_next = (wp_reg == LAST) ? '0 : wp_reg + AW'(1);
      if (pop) rp_next = (rp_reg == LAST) ? '0 : rp_reg + AW'(1);
      cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // storage has no reset, only the pointers and the count do
  always_ff @(posedge clk) begin
    if (push) mem[wp_reg] <= in_data;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : rdm_buf2
`default_nettype wire

// [hw/rdm_cmd_decode.sv]
/*
  host interface word decoder with direct mode control.
  assumes host pins are asynchronous to core_clk and that the
  link clock is much slower than core_clk (sampled, edges found).
*/
`timescale 1ns/1ns
`default_nettype none
module rdm_cmd_decode
  import rdm_pkg::*;
(
  input  wire logic       core_clk,            // 10 MHz core clock
  input  wire logic       rstn,                // async reset, low
  input  wire logic       use_ss,              // 1: select line used
  input  wire logic       spi_sclk,            // host serial clock pin
  input  wire logic       spi_mosi,            // host serial data pin
  input  wire logic       spi_ss_n,            // host select pin, low
  output logic            spi_miso,            // serial read data
  output logic            spi_miso_oe,         // miso driven
  input  wire logic       modulation_input,    // host modulation pin
  input  wire logic       modulation_type_pin, // 0 ASK, 1 OOK
  input  wire logic       env_subcarrier,      // digitized envelope
  input  wire logic       dec_bit,             // bit decoder data
  input  wire logic       dec_clk,             // bit decoder clock
  input  wire logic       tx_engine_mod,       // engine modulation
  input  wire logic       tx_done,             // transmit finished
  input  wire logic       rx_valid,            // framer byte valid
  output logic            rx_ready,            // framer may send
  input  wire logic [7:0] rx_data,             // framer data byte
  output logic            fifo_valid,          // byte to fifo
  input  wire logic       fifo_ready,          // fifo has room
  output logic [7:0]      fifo_data,           // byte to fifo
  output logic            mod_drive,           // to modulator
  output logic            mod_ook,             // 1 OOK, 0 ASK
  output rdm_depth_e      mod_depth,           // ASK depth select
  output logic            sub_out,             // subcarrier pin
  output logic            sub_oe,              // subcarrier pin drive
  output logic            bclk_out,            // bit clock pin
  output logic            bclk_oe,             // bit clock pin drive
  output rdm_cmd_s        cmd,                 // command pulses
  output logic [4:0]      decoder_sel,         // protocol selection
  output logic            decoder_run,         // bit decoder active
  output logic            framer_bypass,       // no framing
  output logic            fifo_en,             // fifo in use
  output logic            irq_en,              // interrupts allowed
  output logic            rx_reset,            // receiver held
  output logic            direct_active,       // in direct mode
  output logic [7:0]      chip_status,         // chip status reg
  output logic [7:0]      proto_ctrl,          // protocol reg
  output logic [7:0]      mod_ctrl             // modulator reg
);
  logic [SYNC_W-1:0] pin_raw, s1_reg, s2_reg;
  logic       sclk_d_reg, mosi_d_reg, ss_d_reg, framed_reg, framed_next;
  logic       rise, fall, stop, start_ns, active, word_done;
  logic [7:0] wd;

  // two-flop synchronisers, one per pin
  assign pin_raw = {modulation_type_pin, dec_clk, dec_bit, env_subcarrier,
                    modulation_input, spi_ss_n, spi_mosi, spi_sclk};
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        s1_reg[i] <= (i == S_SS); // select lane rests high, no false stop
        s2_reg[i] <= (i == S_SS);
      end else begin
        s1_reg[i] <= pin_raw[i];
        s2_reg[i] <= s1_reg[i];
      end
    end
  end

  // edge finding on synchronised serial pins
  assign rise     = s2_reg[S_SCLK] & ~sclk_d_reg;
  assign fall     = ~s2_reg[S_SCLK] & sclk_d_reg;
  assign start_ns = ~use_ss & s2_reg[S_SCLK] & s2_reg[S_MOSI] & ~mosi_d_reg;
  assign stop     = use_ss ? (s2_reg[S_SS] & ~ss_d_reg)
                           : (s2_reg[S_SCLK] & ~s2_reg[S_MOSI] & mosi_d_reg);
  assign active   = use_ss ? ~s2_reg[S_SS] : framed_reg;

  always_comb begin
    framed_next = framed_reg;
    if (stop) framed_next = 1'b0;
    else if (start_ns) framed_next = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
      mosi_d_reg <= 1'b0;
      ss_d_reg   <= 1'b1;
      framed_reg <= 1'b0;
    end else begin
      sclk_d_reg <= s2_reg[S_SCLK];
      mosi_d_reg <= s2_reg[S_MOSI];
      ss_d_reg   <= s2_reg[S_SS];
      framed_reg <= framed_next;
    end
  end

  rdm_state_e state_reg, state_next;
  logic [7:0] sh_reg, sh_next, out_reg, out_next;
  logic [2:0] bit_reg, bit_next;
  logic [4:0] addr_reg, addr_next;
  logic       rd_reg, rd_next, cont_reg, cont_next, miso_reg, miso_next;
  logic [7:0] chip_reg, chip_next, proto_reg, proto_next, modc_reg, modc_next;
  logic       rxb_reg, rxb_next;
  logic       direct, mode1, is_cmd, is_15693;
  rdm_cmd_s   cmd_reg, cmd_next;
  logic [4:0] next_addr;

  // word assembly, msb first
  assign wd        = {sh_reg[6:0], s2_reg[S_MOSI]};
  assign word_done = rise & active & (bit_reg == 3'h7) & ~direct;
  assign direct    = (state_reg == ST_DIRECT);
  assign mode1     = proto_reg[DIR_BIT];
  assign is_cmd    = wd[W_CMD];
  assign is_15693  = (proto_reg[4:2] == 3'h0);
  assign next_addr = cont_reg ? addr_reg + 5'h01 : addr_reg;

  function automatic logic [7:0] reg_rd(input logic [4:0] a, input logic [7:0] c,
                                        input logic [7:0] p, input logic [7:0] m);
    case (a)
      REG_CHIP:  reg_rd = c;
      REG_PROTO: reg_rd = p;
      REG_MOD:   reg_rd = m;
      default:   reg_rd = 8'h00;
    endcase
  endfunction : reg_rd

  // interface state machine, registers and command decode
  always_comb begin
    state_next = state_reg;
    sh_next    = sh_reg;
    bit_next   = bit_reg;
    addr_next  = addr_reg;
    rd_next    = rd_reg;
    cont_next  = cont_reg;
    out_next   = out_reg;
    miso_next  = miso_reg;
    chip_next  = chip_reg;
    proto_next = proto_reg;
    modc_next  = modc_reg;
    rxb_next   = rxb_reg;
    cmd_next   = '0;
    if (rise && active && !direct) begin
      sh_next  = wd;
      bit_next = bit_reg + 3'h1;
    end
    if (fall && state_reg == ST_DATA && rd_reg) begin
      miso_next = out_reg[7];
      out_next  = {out_reg[6:0], 1'b0};
    end
    case (state_reg)
      ST_IDLE: begin
        if (word_done && is_cmd) begin
          case (wd[4:0])
            C_IDLE:  cmd_next.idle = 1'b1;
            C_INIT:  cmd_next.init = 1'b1;
            C_FRST:  cmd_next.fifo_rst = 1'b1;
            C_TXN:   cmd_next.tx_nocrc = 1'b1;
            C_TXC:   cmd_next.tx_crc = 1'b1;
            C_SLOT:  cmd_next.tx_slot = is_15693;
            C_RXBLK: cmd_next.rx_block = 1'b1;
            C_RXEN:  cmd_next.rx_enable = 1'b1;
            C_RFINT: cmd_next.rf_int = 1'b1;
            C_RFEXT: cmd_next.rf_ext = 1'b1;
            C_GAIN:  cmd_next.gain_adj = 1'b1;
            default: cmd_next = '0;
          endcase
          if (wd[4:0] == C_INIT) begin
            chip_next  = CHIP_RST;
            proto_next = PROTO_RST;
            modc_next  = MOD_RST;
          end
        end else if (word_done) begin
          addr_next  = wd[4:0];
          rd_next    = wd[W_RD];
          cont_next  = wd[W_CONT];
          out_next   = reg_rd(wd[4:0], chip_reg, proto_reg, modc_reg);
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (word_done) begin
          addr_next = next_addr;
          out_next  = reg_rd(next_addr, chip_reg, proto_reg, modc_reg);
          if (!rd_reg) begin
            case (addr_reg)
              REG_CHIP:  chip_next = wd;
              REG_PROTO: proto_next = wd;
              REG_MOD:   modc_next = wd;
              default:   chip_next = chip_reg;
            endcase
            if (addr_reg == REG_CHIP && wd[DIR_BIT]) state_next = ST_DIRECT;
          end
        end
      end
      ST_DIRECT: begin
        if (stop) begin
          chip_next[DIR_BIT] = 1'b0;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (!active && !direct && state_reg != ST_WAIT) begin
      bit_next   = 3'h0;
      state_next = ST_IDLE;
      miso_next  = 1'b0;
    end
    if (cmd_next.rx_enable || cmd_next.init || tx_done) rxb_next = 1'b0;
    if (cmd_next.rx_block) rxb_next = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      sh_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      addr_reg  <= 5'h00;
      rd_reg    <= 1'b0;
      cont_reg  <= 1'b0;
      out_reg   <= 8'h00;
      miso_reg  <= 1'b0;
      chip_reg  <= CHIP_RST;
      proto_reg <= PROTO_RST;
      modc_reg  <= MOD_RST;
      rxb_reg   <= 1'b0;
      cmd_reg   <= '0;
    end else begin
      state_reg <= state_next;
      sh_reg    <= sh_next;
      bit_reg   <= bit_next;
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      cont_reg  <= cont_next;
      out_reg   <= out_next;
      miso_reg  <= miso_next;
      chip_reg  <= chip_next;
      proto_reg <= proto_next;
      modc_reg  <= modc_next;
      rxb_reg   <= rxb_next;
      cmd_reg   <= cmd_next;
    end
  end

  logic       modp_reg, modp_next, sub_reg, sub_next, soe_reg, soe_next;
  logic       bck_reg, bck_next, boe_reg, boe_next;
  rdm_depth_e dep_reg, dep_next;

  // pin routing for direct and normal operation
  always_comb begin
    modp_next = direct ? s2_reg[S_MOD] : tx_engine_mod;
    sub_next  = mode1 ? s2_reg[S_DBIT] : s2_reg[S_SUB];
    soe_next  = direct;
    bck_next  = mode1 & s2_reg[S_DCLK];
    boe_next  = direct & mode1;
    case (modc_reg[2:0])
      M_OOK:   dep_next = DEP_OOK;
      M_ASK10: dep_next = DEP_ASK10;
      M_ASK13: dep_next = DEP_ASK13;
      M_ASK16: dep_next = DEP_ASK16;
      default: dep_next = DEP_ASK10;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      modp_reg <= 1'b0;
      sub_reg  <= 1'b0;
      soe_reg  <= 1'b0;
      bck_reg  <= 1'b0;
      boe_reg  <= 1'b0;
      dep_reg  <= DEP_ASK10;
    end else begin
      modp_reg <= modp_next;
      sub_reg  <= sub_next;
      soe_reg  <= soe_next;
      bck_reg  <= bck_next;
      boe_reg  <= boe_next;
      dep_reg  <= dep_next;
    end
  end

  logic buf_in_ready;

  // framed receive bytes toward the fifo, shut off while direct
  rdm_buf2 #(.W(8), .DEPTH(2)) u_buf (
    .clk       (core_clk),
    .rstn      (rstn),
    .clr       (cmd_reg.fifo_rst | cmd_reg.init),
    .in_valid  (rx_valid & ~direct),
    .in_ready  (buf_in_ready),
    .in_data   (rx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // outputs
  assign rx_ready      = buf_in_ready & ~direct;
  assign fifo_en       = ~direct;
  assign irq_en        = ~direct;
  assign decoder_sel   = proto_reg[4:0];
  assign decoder_run   = ~direct | mode1;
  assign framer_bypass = direct;
  assign rx_reset      = rxb_reg;
  assign direct_active = direct;
  assign spi_miso      = miso_reg;
  assign spi_miso_oe   = (state_reg == ST_DATA) & rd_reg & active;
  assign mod_drive     = modp_reg;
  assign mod_ook       = s2_reg[S_MTYP];
  assign mod_depth     = dep_reg;
  assign sub_out       = sub_reg;
  assign sub_oe        = soe_reg;
  assign bclk_out      = bck_reg;
  assign bclk_oe       = boe_reg;
  assign cmd           = cmd_reg;
  assign chip_status   = chip_reg;
  assign proto_ctrl    = proto_reg;
  assign mod_ctrl      = modc_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_dir_write;
    word_done && state_reg == ST_DATA && !rd_reg && addr_reg == REG_CHIP && wd[DIR_BIT];
  endsequence
  sequence s_dir_stop;
    direct && stop;
  endsequence

  a_direct_entry: assert property (s_dir_write |=> direct && chip_reg[DIR_BIT])
    else $error("direct mode not entered");
  a_stop_exit: assert property (s_dir_stop |=> !direct && !chip_reg[DIR_BIT] ##1 state_reg == ST_IDLE)
    else $error("direct mode not left on stop");
  a_pins_release: assert property ($fell(direct) |-> ##[1:2] !sub_oe && !bclk_oe)
    else $error("direct pins still driven");
  a_mode0_route: assert property (direct && !mode1 ##1 direct |-> mod_drive == $past(s2_reg[S_MOD]))
    else $error("modulation not passed through");
  a_mode1_clock: assert property (direct && mode1 |=> bclk_oe && sub_out == $past(s2_reg[S_DBIT]))
    else $error("bit clock pin not driven");
  a_no_fifo_irq: assert property (direct |-> !fifo_en && !irq_en && !rx_ready)
    else $error("fifo or irq active in direct");
  a_no_reg_access: assert property (direct ##1 direct |-> $stable(proto_reg) && $stable(modc_reg))
    else $error("register changed in direct");
  a_init_cmd: assert property (word_done && state_reg == ST_IDLE && wd == {3'b100, C_INIT}
                               |=> cmd.init && proto_reg == PROTO_RST && chip_reg == CHIP_RST)
    else $error("software init failed");
  a_addr_decode: assert property (word_done && state_reg == ST_IDLE && !wd[W_CMD]
                                  |=> state_reg == ST_DATA && rd_reg == $past(wd[W_RD]))
    else $error("address word misread");
  a_rx_block: assert property (cmd.rx_block |-> rx_reset)
    else $error("receiver not blocked");
  a_slot_gate: assert property (cmd.tx_slot |-> $past(is_15693))
    else $error("slot command in wrong protocol");
endmodule : rdm_cmd_decode
`default_nettype wire

// [hw/rdm_pkg.sv]
/*
  constants and types for the direct-mode command decoder.
  assumes nothing beyond a standard systemverilog compiler.
*/
package rdm_pkg;
  // register addresses and field positions
  localparam logic [4:0] REG_CHIP  = 5'h00;
  localparam logic [4:0] REG_PROTO = 5'h01;
  localparam logic [4:0] REG_MOD   = 5'h09;
  localparam int         DIR_BIT   = 6;   // direct_select_bit
  localparam int         W_CMD     = 7;
  localparam int         W_RD      = 6;
  localparam int         W_CONT    = 5;
  // values after reset or software init
  localparam logic [7:0] CHIP_RST  = 8'h00;
  localparam logic [7:0] PROTO_RST = 8'h02;
  localparam logic [7:0] MOD_RST   = 8'h00;
  // command codes
  localparam logic [4:0] C_IDLE  = 5'h00;
  localparam logic [4:0] C_INIT  = 5'h03;
  localparam logic [4:0] C_FRST  = 5'h0F;
  localparam logic [4:0] C_TXN   = 5'h10;
  localparam logic [4:0] C_TXC   = 5'h11;
  localparam logic [4:0] C_SLOT  = 5'h14;
  localparam logic [4:0] C_RXBLK = 5'h16;
  localparam logic [4:0] C_RXEN  = 5'h17;
  localparam logic [4:0] C_RFINT = 5'h18;
  localparam logic [4:0] C_RFEXT = 5'h19;
  localparam logic [4:0] C_GAIN  = 5'h1A;
  // modulator field codes (low bits of modulator register)
  localparam logic [2:0] M_OOK   = 3'h1;
  localparam logic [2:0] M_ASK10 = 3'h0;
  localparam logic [2:0] M_ASK13 = 3'h4;
  localparam logic [2:0] M_ASK16 = 3'h5;
  // synchroniser lanes
  localparam int S_SCLK = 0;
  localparam int S_MOSI = 1;
  localparam int S_SS   = 2;
  localparam int S_MOD  = 3;
  localparam int S_SUB  = 4;
  localparam int S_DBIT = 5;
  localparam int S_DCLK = 6;
  localparam int S_MTYP = 7;
  localparam int SYNC_W = 8;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_DATA   = 4'h2,
    ST_DIRECT = 4'h4,
    ST_WAIT   = 4'h8
  } rdm_state_e;

  typedef enum logic [1:0] {
    DEP_ASK10 = 2'h0,
    DEP_OOK   = 2'h1,
    DEP_ASK13 = 2'h2,
    DEP_ASK16 = 2'h3
  } rdm_depth_e;

  typedef struct packed {
    logic idle;
    logic init;
    logic fifo_rst;
    logic tx_nocrc;
    logic tx_crc;
    logic tx_slot;
    logic rx_block;
    logic rx_enable;
    logic rf_int;
    logic rf_ext;
    logic gain_adj;
  } rdm_cmd_s;
endpackage : rdm_pkg

// [testbench/rdm_host_model.sv]
/*
  host microcontroller model: framed 8-bit words msb first, reads.
  assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ns
`default_nettype none
module rdm_host_model (
  input  wire logic use_ss, // 1: select framing
  input  wire logic miso,   // read data line
  output logic      sclk,   // link clock, idle low
  output logic      mosi,   // link data
  output logic      ss_n    // select, low
);
  logic [7:0] rd_byte; // last byte read
  // link idle: clock still, select high
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  // data edge while clock high marks start or stop
  task automatic delim(input logic v);
    mosi = ~v;
    #400;
    sclk = 1'b1;
    #400;
    mosi = v;
    #400;
    sclk = 1'b0;
    #400;
  endtask : delim
  // open a frame, offset from the core clock
  task automatic start;
    #13;
    if (use_ss) ss_n = 1'b0;
    else delim(1'b1);
    #400;
  endtask : start
  // close a frame
  task automatic stop;
    #400;
    if (use_ss) ss_n = 1'b1;
    else delim(1'b0);
    #400;
  endtask : stop
  // one word out, read bit taken before the clock falls
  task automatic xf(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #400;
      sclk = 1'b1;
      #400;
      rd_byte[i] = miso;
      sclk = 1'b0;
    end
  endtask : xf
endmodule : rdm_host_model
`default_nettype wire

// [testbench/tb_rfid_direct_mode_command_decode.sv]
/*
  bench for the direct-mode command decoder: host model, random pins, buffer.
  assumes rdm_pkg and rdm_host_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb_rfid_direct_mode_command_decode;
  import rdm_pkg::*;
  logic core_clk, rstn, use_ss, spi_sclk, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe;
  logic modulation_input, modulation_type_pin, env_subcarrier, dec_bit, dec_clk;
  logic tx_engine_mod, tx_done, rx_valid, rx_ready, fifo_valid, fifo_ready, mod_drive;
  logic mod_ook, sub_out, sub_oe, bclk_out, bclk_oe, decoder_run, framer_bypass;
  logic fifo_en, irq_en, rx_reset, direct_active, dir, m1, acc;
  logic [7:0] rx_data, fifo_data, chip_status, proto_ctrl, mod_ctrl, q[$];
  logic [4:0] decoder_sel;
  rdm_depth_e mod_depth;
  rdm_cmd_s cmd, seen;
  logic seen_clr;
  logic [7:0] exp_b;
  logic [31:0] seed = 32'h118CF0A0;
  int bad_count = 0, compares = 0;
  logic [7:0] mods[4] = '{8'h21, 8'h20, 8'h24, 8'h25};
  logic [7:0] rdx[3] = '{8'h00, 8'h25, 8'h00};
  logic [7:0] protos[2] = '{8'h02, 8'h42};
  logic [4:0] codes[12] = '{5'h00, 5'h03, 5'h0F, 5'h10, 5'h11, 5'h14, 5'h16, 5'h17,
                            5'h18, 5'h19, 5'h1A, 5'h1B};
  rdm_cmd_decode u_dut (.core_clk, .rstn, .use_ss, .spi_sclk, .spi_mosi, .spi_ss_n,
    .spi_miso, .spi_miso_oe, .modulation_input, .modulation_type_pin, .env_subcarrier,
    .dec_bit, .dec_clk, .tx_engine_mod, .tx_done, .rx_valid, .rx_ready, .rx_data,
    .fifo_valid, .fifo_ready, .fifo_data, .mod_drive, .mod_ook, .mod_depth, .sub_out,
    .sub_oe, .bclk_out, .bclk_oe, .cmd, .decoder_sel, .decoder_run, .framer_bypass,
    .fifo_en, .irq_en, .rx_reset, .direct_active, .chip_status, .proto_ctrl, .mod_ctrl);
  // released read line shows the inverse of the last bit
  rdm_host_model u_host (.use_ss, .miso(spi_miso_oe ? spi_miso : ~spi_miso),
    .sclk(spi_sclk), .mosi(spi_mosi), .ss_n(spi_ss_n));
  // core clock and sticky record of command pulses
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) seen <= seen_clr ? cmd : seen | cmd;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic rdm_depth_e depth(input logic [2:0] m);
    return m == 3'h1 ? DEP_OOK : m == 3'h4 ? DEP_ASK13 : m == 3'h5 ? DEP_ASK16 : DEP_ASK10;
  endfunction : depth
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.start();
    u_host.xf({3'b000, a});
    u_host.xf(d);
    u_host.stop();
    cyc(2);
  endtask : wr
  // random pin values, then the pass-through paths
  task automatic pins;
    seed = lfsr(seed);
    {modulation_input, modulation_type_pin, env_subcarrier, dec_bit, dec_clk,
     tx_engine_mod} = seed[5:0];
    cyc(6);
    `CHK(mod_ook, modulation_type_pin)
    `CHK(mod_drive, dir ? modulation_input : tx_engine_mod)
    if (dir) `CHK(sub_out, m1 ? dec_bit : env_subcarrier)
    if (dir && m1) `CHK(bclk_out, dec_clk)
  endtask : pins
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #3000000;
    bad_count++;
    end_sim();
  end
  initial begin
    {rstn, use_ss, dir, m1, modulation_input, modulation_type_pin} = '0;
    {env_subcarrier, dec_bit, dec_clk, tx_engine_mod, tx_done, rx_valid, fifo_ready} = '0;
    rx_data = 8'h00;
    seen_clr = 1'b1;
    cyc(8);
    rstn = 1'b1;
    seen_clr = 1'b0;
    cyc(4);
    `CHK({chip_status, proto_ctrl, mod_ctrl, fifo_en, irq_en}, 26'h0000803)
    `CHK({spi_miso_oe, decoder_run, rx_reset}, 3'b010)
    // fill the buffer against a stalled sink, then drain it
    rx_valid = 1'b1;
    repeat (4) begin
      acc = (rx_ready === 1'b1);
      if (acc) q.push_back(rx_data);
      cyc(1);
      seed = lfsr(seed);
      if (acc) rx_data = seed[7:0];
    end
    `CHK({q.size() == 2, rx_ready}, 2'b10)
    rx_valid = 1'b0;
    fifo_ready = 1'b1;
    repeat (4) begin
      if (fifo_valid === 1'b1 && q.size() > 0) begin
        exp_b = q.pop_front();
        `CHK(fifo_data, exp_b)
      end
      cyc(1);
    end
    `CHK({q.size() == 0, fifo_valid}, 2'b10)
    // modulator codes over the link without select
    foreach (mods[i]) begin
      wr(REG_MOD, mods[i]);
      `CHK({mod_ctrl, mod_depth}, {mods[i], depth(mods[i][2:0])})
      pins();
    end
    u_host.start();
    u_host.xf(8'h68);
    foreach (rdx[i]) begin
      u_host.xf(8'h00);
      `CHK(u_host.rd_byte, rdx[i])
    end
    u_host.stop();
    // every command code in one framed burst, one unknown code
    cyc(2);
    use_ss = 1'b1;
    u_host.start();
    foreach (codes[i]) begin
      seen_clr = 1'b1;
      cyc(1);
      seen_clr = 1'b0;
      u_host.xf({3'b100, codes[i]});
      cyc(4);
      `CHK(seen, i < 11 ? 11'h400 >> i : 11'h000)
      `CHK(rx_reset, i == 6)
    end
    u_host.stop();
    `CHK(mod_ctrl, 8'h00)
    // both direct modes: entry, blocked access, stop exit
    foreach (protos[i]) begin
      m1 = protos[i][6];
      wr(REG_MOD, 8'h61);
      wr(REG_PROTO, protos[i]);
      u_host.start();
      u_host.xf({3'b000, REG_CHIP});
      u_host.xf(8'h40);
      cyc(4);
      dir = 1'b1;
      `CHK({direct_active, chip_status, sub_oe, bclk_oe}, {1'b1, 8'h40, 1'b1, m1})
      `CHK({fifo_en, irq_en, rx_ready}, 3'b000)
      `CHK(decoder_run, m1)
      if (m1) `CHK({framer_bypass, decoder_sel}, 6'h22)
      repeat (3) pins();
      u_host.xf(8'h09);
      u_host.xf(8'h00);
      cyc(4);
      `CHK(mod_ctrl, 8'h61)
      u_host.stop();
      cyc(4);
      dir = 1'b0;
      `CHK({direct_active, chip_status, sub_oe, bclk_oe}, 11'h000)
      pins();
    end
    // next slot refused outside the vicinity protocol, transmit end lifts the block
    wr(REG_PROTO, 8'h0C);
    seen_clr = 1'b1;
    cyc(1);
    seen_clr = 1'b0;
    u_host.start();
    u_host.xf({3'b100, C_SLOT});
    u_host.xf({3'b100, C_RXBLK});
    cyc(4);
    `CHK({seen, decoder_sel, rx_reset}, {11'h010, 5'h0C, 1'b1})
    tx_done = 1'b1;
    cyc(1);
    tx_done = 1'b0;
    cyc(1);
    `CHK(rx_reset, 1'b0)
    u_host.stop();
    end_sim();
  end
endmodule : tb_rfid_direct_mode_command_decode
`default_nettype wire
